// File: shared/lts_pkg.sv
// Constants, types and register map of the layered trigger sequencer
package lts_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS         = 1_000_000;
  localparam int MS_CYCLES     = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PRE_W         = 17;

  // ----------------------------------------------------------------
  // Widths and limits
  // ----------------------------------------------------------------
  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 32;
  localparam int MS_W     = 30;
  localparam int CNT_W    = 17;
  localparam int SRC_W    = 3;
  localparam int TB_LINES = 6;
  localparam int TB_SEL_W = 3;
  localparam logic [MS_W-1:0]  MS_MAX   = 30'h3B9AC9FF;
  localparam logic [MS_W-1:0]  MS_ONE   = 30'h0000001;
  localparam logic [CNT_W-1:0] LOOP_MAX = 17'h1869F;
  localparam logic [CNT_W-1:0] CNT_ONE  = 17'h00001;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] REG_CTRL       = 8'h00;
  localparam logic [ADDR_W-1:0] REG_SCAN_DELAY = 8'h04;
  localparam logic [ADDR_W-1:0] REG_SCAN_TIMER = 8'h08;
  localparam logic [ADDR_W-1:0] REG_SCAN_COUNT = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_ARM_COUNT  = 8'h10;
  localparam logic [ADDR_W-1:0] REG_ALARM_TIME = 8'h14;
  localparam logic [ADDR_W-1:0] REG_ALARM_DATE = 8'h18;
  localparam logic [ADDR_W-1:0] REG_STATUS     = 8'h1C;
  localparam logic [ADDR_W-1:0] REG_SCAN_PASS  = 8'h20;
  localparam logic [ADDR_W-1:0] REG_ARM_PASS   = 8'h24;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_START    = 0;
  localparam int CTRL_ARM_SRC  = 1;
  localparam int CTRL_SCAN_SRC = 4;
  localparam int CTRL_ARM_BYP  = 7;
  localparam int CTRL_SCAN_BYP = 8;
  localparam int CTRL_MEAS_BYP = 9;
  localparam int CTRL_TB_IN    = 10;
  localparam int CTRL_TB_OUT   = 13;
  localparam int TIME_SEC      = 0;
  localparam int TIME_MIN      = 6;
  localparam int TIME_HOUR     = 12;
  localparam int TIME_PM       = 17;
  localparam int TIME_FMT12    = 18;
  localparam int DATE_DAY      = 0;
  localparam int DATE_MONTH    = 5;
  localparam int DATE_YEAR     = 9;
  localparam int STAT_STATE    = 0;
  localparam int STAT_CLASH    = 3;
  localparam int STAT_TMR_DONE = 4;

  localparam logic [4:0] HOURS_HALF_DAY = 5'h0C;

  // ----------------------------------------------------------------
  // Event sources
  // ----------------------------------------------------------------
  localparam logic [SRC_W-1:0] SRC_IMM   = 3'h0;
  localparam logic [SRC_W-1:0] SRC_EXT   = 3'h1;
  localparam logic [SRC_W-1:0] SRC_MAN   = 3'h2;
  localparam logic [SRC_W-1:0] SRC_BUS   = 3'h3;
  localparam logic [SRC_W-1:0] SRC_TBUS  = 3'h4;
  localparam logic [SRC_W-1:0] SRC_TIMER = 3'h5;
  localparam logic [SRC_W-1:0] SRC_CAL   = 3'h6;
  localparam logic [SRC_W-1:0] SRC_HOLD  = 3'h7;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    LTS_IDLE, LTS_ARM_WAIT, LTS_SCAN_WAIT, LTS_SCAN_DELAY, LTS_MEAS_WAIT, LTS_ACTION
  } lts_layer_t;

  typedef struct packed {
    logic                ext_pulse;
    logic                fire_key;
    logic                bus_front_panel_fire_key;
    logic                meas_event;
    logic                act_done;
    logic [TB_LINES-1:0] tbus_in;
  } lts_evt_t;

  typedef struct packed {
    logic [11:0] year;
    logic [3:0]  month;
    logic [4:0]  day;
    logic [4:0]  hour;
    logic [5:0]  minute;
    logic [5:0]  second;
  } lts_cal_t;

  typedef struct packed {
    lts_layer_t          st;
    logic [SRC_W-1:0]    arm_src;
    logic [SRC_W-1:0]    scan_src;
    logic                arm_byp;
    logic                scan_byp;
    logic                meas_byp;
    logic [TB_SEL_W-1:0] tb_in_sel;
    logic [TB_SEL_W-1:0] tb_out_sel;
    logic [MS_W-1:0]     scan_delay;
    logic [MS_W-1:0]     scan_interval;
    logic [CNT_W-1:0]    scan_count;
    logic [CNT_W-1:0]    arm_count;
    lts_cal_t            alarm;
    logic                alarm_pm;
    logic                alarm_fmt12;
    logic                arm_first;
    logic                scan_first;
    logic                meas_first;
    logic [CNT_W-1:0]    arm_cnt;
    logic [CNT_W-1:0]    scan_cnt;
    logic [MS_W-1:0]     dly_ms;
    logic [PRE_W-1:0]    dly_pre;
    logic [MS_W-1:0]     tmr_ms;
    logic [PRE_W-1:0]    tmr_pre;
    logic                tmr_run;
    logic                tmr_done;
    lts_evt_t            evt_prev;
    logic                cal_prev;
    logic [DATA_W-1:0]   rd_data;
    logic                act_start;
    logic                done_out;
    logic                ext_out;
    logic [TB_LINES-1:0] tbus_out;
  } lts_state_t;

endpackage

// File: src/lts_sequencer.sv
// Arm, scan and measure layer trigger sequencer with register port
`timescale 1ns/1ps

module lts_sequencer #(
  parameter int MS_CYCLES = lts_pkg::MS_CYCLES
) (
  input  wire logic                                sys_clk,
  input  wire logic                                rst,
  input  wire logic [lts_pkg::ADDR_W-1:0]          reg_addr,
  input  wire logic [lts_pkg::DATA_W-1:0]          reg_wdata,
  input  wire logic                                reg_wr,
  input  wire logic                                reg_rd,
  output logic      [lts_pkg::DATA_W-1:0]          reg_rdata,
  input  wire lts_pkg::lts_evt_t                   evt_in,
  input  wire lts_pkg::lts_cal_t                   cal_now,
  output logic                                     act_start,
  output logic                                     done_out,
  output logic                                     ext_out,
  output logic      [lts_pkg::TB_LINES-1:0]        tbus_out
);

  localparam logic [lts_pkg::PRE_W-1:0] PRE_LAST = lts_pkg::PRE_W'(MS_CYCLES - 1);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic src_hit(
    input logic [lts_pkg::SRC_W-1:0] src,
    input logic                      ext,
    input logic                      key,
    input logic                      bus,
    input logic                      tb,
    input logic                      tmr,
    input logic                      cal
  );
    case (src)
      lts_pkg::SRC_IMM:   src_hit = 1'b1;
      lts_pkg::SRC_EXT:   src_hit = ext | key;
      lts_pkg::SRC_MAN:   src_hit = key;
      lts_pkg::SRC_BUS:   src_hit = bus | key;
      lts_pkg::SRC_TBUS:  src_hit = tb | key;
      lts_pkg::SRC_TIMER: src_hit = tmr;
      lts_pkg::SRC_CAL:   src_hit = cal;
      lts_pkg::SRC_HOLD:  src_hit = 1'b0;
      default:            src_hit = 1'b0;
    endcase
  endfunction

  function automatic logic [lts_pkg::MS_W-1:0] clamp_ms(
    input logic [lts_pkg::DATA_W-1:0] v,
    input logic                       nonzero
  );
    if (v > lts_pkg::DATA_W'(lts_pkg::MS_MAX))
      clamp_ms = lts_pkg::MS_MAX;
    else if (nonzero && v == '0)
      clamp_ms = lts_pkg::MS_ONE;
    else
      clamp_ms = v[lts_pkg::MS_W-1:0];
  endfunction

  function automatic logic [lts_pkg::CNT_W-1:0] clamp_cnt(input logic [lts_pkg::DATA_W-1:0] v);
    if (v > lts_pkg::DATA_W'(lts_pkg::LOOP_MAX))
      clamp_cnt = lts_pkg::LOOP_MAX;
    else
      clamp_cnt = v[lts_pkg::CNT_W-1:0];
  endfunction

  // Zero count means loop forever
  function automatic logic loop_again(
    input logic [lts_pkg::CNT_W-1:0] limit,
    input logic [lts_pkg::CNT_W-1:0] done_cnt
  );
    loop_again = (limit == '0) || (done_cnt + lts_pkg::CNT_ONE < limit);
  endfunction

  function automatic logic [4:0] hour_24(
    input logic [4:0] h,
    input logic       pm,
    input logic       fmt12
  );
    if (!fmt12)
      hour_24 = h;
    else if (h == lts_pkg::HOURS_HALF_DAY)
      hour_24 = pm ? lts_pkg::HOURS_HALF_DAY : 5'h00;
    else
      hour_24 = pm ? h + lts_pkg::HOURS_HALF_DAY : h;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  lts_pkg::lts_state_t s_reg;
  lts_pkg::lts_state_t s_next;

  assign reg_rdata = s_reg.rd_data;
  assign act_start = s_reg.act_start;
  assign done_out  = s_reg.done_out;
  assign ext_out   = s_reg.ext_out;
  assign tbus_out  = s_reg.tbus_out;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    lts_pkg::lts_evt_t rise;
    logic              clash;
    logic              tb_edge;
    logic              cal_match;
    logic              arm_ev;
    logic              scan_ev;
    logic              meas_ev;
    logic              front_panel_fire_key_pulse;
    logic              tbus_src;
    rise       = '0;
    clash      = 1'b0;
    tb_edge    = 1'b0;
    cal_match  = 1'b0;
    arm_ev     = 1'b0;
    scan_ev    = 1'b0;
    meas_ev    = 1'b0;
    front_panel_fire_key_pulse = 1'b0;
    tbus_src   = 1'b0;
    s_next     = s_reg;

    s_next.act_start = 1'b0;
    s_next.done_out  = 1'b0;
    s_next.ext_out   = 1'b0;
    s_next.tbus_out  = '0;
    s_next.rd_data   = '0;

    // Edges only count where a wait state looks at them; no queueing
    rise            = evt_in & ~s_reg.evt_prev;
    s_next.evt_prev = evt_in;

    clash = (s_reg.tb_in_sel == s_reg.tb_out_sel)
         || (s_reg.tb_in_sel >= lts_pkg::TB_SEL_W'(lts_pkg::TB_LINES));
    if (!clash)
      tb_edge = rise.tbus_in[s_reg.tb_in_sel];

    cal_match = (cal_now.second == s_reg.alarm.second)
             && (cal_now.minute == s_reg.alarm.minute)
             && (cal_now.hour   == hour_24(s_reg.alarm.hour, s_reg.alarm_pm,
                                           s_reg.alarm_fmt12))
             && (cal_now.day    == s_reg.alarm.day)
             && (cal_now.month  == s_reg.alarm.month)
             && (cal_now.year   == s_reg.alarm.year);
    s_next.cal_prev = cal_match;

    arm_ev = (s_reg.arm_first && s_reg.arm_byp)
          || src_hit(s_reg.arm_src, rise.ext_pulse, rise.fire_key, rise.bus_front_panel_fire_key,
                     tb_edge, 1'b0, cal_match && !s_reg.cal_prev);
    scan_ev = (s_reg.scan_first && s_reg.scan_byp)
           || src_hit(s_reg.scan_src, rise.ext_pulse, rise.fire_key, rise.bus_front_panel_fire_key,
                      tb_edge, s_reg.tmr_done || rise.fire_key, 1'b0);
    meas_ev = (s_reg.meas_first && s_reg.meas_byp) || rise.meas_event;

    // ---------------- Scan interval timer ----------------
    // Runs through the whole sequence; a late expiry waits at scan wait
    if (s_reg.tmr_run)
    begin
      if (s_reg.tmr_pre == PRE_LAST)
      begin
        s_next.tmr_pre = '0;
        s_next.tmr_ms  = s_reg.tmr_ms - lts_pkg::MS_ONE;
        if (s_reg.tmr_ms == lts_pkg::MS_ONE)
        begin
          s_next.tmr_run  = 1'b0;
          s_next.tmr_done = 1'b1;
        end
      end
      else
        s_next.tmr_pre = s_reg.tmr_pre + 1'b1;
    end

    // ---------------- Layer sequencing ----------------
    case (s_reg.st)
      lts_pkg::LTS_IDLE:
      begin
        if (reg_wr && reg_addr == lts_pkg::REG_CTRL && reg_wdata[lts_pkg::CTRL_START])
        begin
          s_next.st        = lts_pkg::LTS_ARM_WAIT;
          s_next.arm_first = 1'b1;
          s_next.arm_cnt   = '0;
        end
      end
      lts_pkg::LTS_ARM_WAIT:
      begin
        if (arm_ev)
        begin
          s_next.st         = lts_pkg::LTS_SCAN_WAIT;
          s_next.arm_first  = 1'b0;
          s_next.scan_first = 1'b1;
          s_next.scan_cnt   = '0;
          s_next.tmr_done   = 1'b1; // First timed scan starts at once
          s_next.tmr_run    = 1'b0;
        end
      end
      lts_pkg::LTS_SCAN_WAIT:
      begin
        if (scan_ev)
        begin
          s_next.scan_first = 1'b0;
          s_next.tmr_done   = 1'b0;
          s_next.tmr_run    = 1'b1;
          s_next.tmr_pre    = '0;
          s_next.tmr_ms     = s_reg.scan_interval;
          s_next.dly_ms     = s_reg.scan_delay;
          s_next.dly_pre    = '0;
          if (s_reg.scan_delay == '0)
          begin
            s_next.st         = lts_pkg::LTS_MEAS_WAIT;
            s_next.meas_first = 1'b1;
          end
          else
            s_next.st = lts_pkg::LTS_SCAN_DELAY;
        end
      end
      lts_pkg::LTS_SCAN_DELAY:
      begin
        if (s_reg.dly_pre == PRE_LAST)
        begin
          s_next.dly_pre = '0;
          s_next.dly_ms  = s_reg.dly_ms - lts_pkg::MS_ONE;
          if (s_reg.dly_ms == lts_pkg::MS_ONE)
          begin
            s_next.st         = lts_pkg::LTS_MEAS_WAIT;
            s_next.meas_first = 1'b1;
          end
        end
        else
          s_next.dly_pre = s_reg.dly_pre + 1'b1;
      end
      lts_pkg::LTS_MEAS_WAIT:
      begin
        if (meas_ev)
        begin
          s_next.st         = lts_pkg::LTS_ACTION;
          s_next.meas_first = 1'b0;
          s_next.act_start  = 1'b1;
        end
      end
      lts_pkg::LTS_ACTION:
      begin
        if (rise.act_done)
        begin
          s_next.done_out = 1'b1;
          if (loop_again(s_reg.scan_count, s_reg.scan_cnt))
          begin
            s_next.st       = lts_pkg::LTS_SCAN_WAIT;
            s_next.scan_cnt = s_reg.scan_cnt + lts_pkg::CNT_ONE;
            front_panel_fire_key_pulse      = s_reg.scan_byp;
            tbus_src        = (s_reg.scan_src == lts_pkg::SRC_TBUS);
          end
          else
          begin
            s_next.scan_cnt = '0;
            front_panel_fire_key_pulse      = s_reg.arm_byp;
            tbus_src        = (s_reg.arm_src == lts_pkg::SRC_TBUS);
            if (loop_again(s_reg.arm_count, s_reg.arm_cnt))
            begin
              s_next.st      = lts_pkg::LTS_ARM_WAIT;
              s_next.arm_cnt = s_reg.arm_cnt + lts_pkg::CNT_ONE;
            end
            else
            begin
              s_next.st      = lts_pkg::LTS_IDLE;
              s_next.arm_cnt = '0;
            end
          end
        end
      end
      default:
        s_next.st = lts_pkg::LTS_IDLE;
    endcase

    // Return-path trigger goes to the bus line when that source uses it and the selected lines are valid and distinct
    if (front_panel_fire_key_pulse)
    begin
      if (tbus_src && !clash && (s_reg.tb_out_sel < lts_pkg::TB_SEL_W'(lts_pkg::TB_LINES)))
        s_next.tbus_out[s_reg.tb_out_sel] = 1'b1;
      else
        s_next.ext_out = 1'b1;
    end

    // ---------------- Register writes ----------------
    if (reg_wr)
    begin
      case (reg_addr)
        lts_pkg::REG_CTRL:
        begin
          s_next.arm_src    = reg_wdata[lts_pkg::CTRL_ARM_SRC +: lts_pkg::SRC_W];
          s_next.scan_src   = reg_wdata[lts_pkg::CTRL_SCAN_SRC +: lts_pkg::SRC_W];
          s_next.arm_byp    = reg_wdata[lts_pkg::CTRL_ARM_BYP];
          s_next.scan_byp   = reg_wdata[lts_pkg::CTRL_SCAN_BYP];
          s_next.meas_byp   = reg_wdata[lts_pkg::CTRL_MEAS_BYP];
          s_next.tb_in_sel  = reg_wdata[lts_pkg::CTRL_TB_IN +: lts_pkg::TB_SEL_W];
          s_next.tb_out_sel = reg_wdata[lts_pkg::CTRL_TB_OUT +: lts_pkg::TB_SEL_W];
        end
        lts_pkg::REG_SCAN_DELAY: s_next.scan_delay    = clamp_ms(reg_wdata, 1'b0);
        lts_pkg::REG_SCAN_TIMER: s_next.scan_interval = clamp_ms(reg_wdata, 1'b1);
        lts_pkg::REG_SCAN_COUNT: s_next.scan_count    = clamp_cnt(reg_wdata);
        lts_pkg::REG_ARM_COUNT:  s_next.arm_count     = clamp_cnt(reg_wdata);
        lts_pkg::REG_ALARM_TIME:
        begin
          s_next.alarm.second = reg_wdata[lts_pkg::TIME_SEC +: 6];
          s_next.alarm.minute = reg_wdata[lts_pkg::TIME_MIN +: 6];
          s_next.alarm.hour   = reg_wdata[lts_pkg::TIME_HOUR +: 5];
          s_next.alarm_pm     = reg_wdata[lts_pkg::TIME_PM];
          s_next.alarm_fmt12  = reg_wdata[lts_pkg::TIME_FMT12];
        end
        lts_pkg::REG_ALARM_DATE:
        begin
          s_next.alarm.day   = reg_wdata[lts_pkg::DATE_DAY +: 5];
          s_next.alarm.month = reg_wdata[lts_pkg::DATE_MONTH +: 4];
          s_next.alarm.year  = reg_wdata[lts_pkg::DATE_YEAR +: 12];
        end
        default:
        begin
        end
      endcase
    end

    // ---------------- Register reads ----------------
    if (reg_rd)
    begin
      case (reg_addr)
        lts_pkg::REG_CTRL:
        begin
          s_next.rd_data[lts_pkg::CTRL_ARM_SRC +: lts_pkg::SRC_W]   = s_reg.arm_src;
          s_next.rd_data[lts_pkg::CTRL_SCAN_SRC +: lts_pkg::SRC_W]  = s_reg.scan_src;
          s_next.rd_data[lts_pkg::CTRL_ARM_BYP]                     = s_reg.arm_byp;
          s_next.rd_data[lts_pkg::CTRL_SCAN_BYP]                    = s_reg.scan_byp;
          s_next.rd_data[lts_pkg::CTRL_MEAS_BYP]                    = s_reg.meas_byp;
          s_next.rd_data[lts_pkg::CTRL_TB_IN +: lts_pkg::TB_SEL_W]  = s_reg.tb_in_sel;
          s_next.rd_data[lts_pkg::CTRL_TB_OUT +: lts_pkg::TB_SEL_W] = s_reg.tb_out_sel;
        end
        lts_pkg::REG_SCAN_DELAY: s_next.rd_data[lts_pkg::MS_W-1:0]  = s_reg.scan_delay;
        lts_pkg::REG_SCAN_TIMER: s_next.rd_data[lts_pkg::MS_W-1:0]  = s_reg.scan_interval;
        lts_pkg::REG_SCAN_COUNT: s_next.rd_data[lts_pkg::CNT_W-1:0] = s_reg.scan_count;
        lts_pkg::REG_ARM_COUNT:  s_next.rd_data[lts_pkg::CNT_W-1:0] = s_reg.arm_count;
        lts_pkg::REG_ALARM_TIME:
        begin
          s_next.rd_data[lts_pkg::TIME_SEC +: 6]  = s_reg.alarm.second;
          s_next.rd_data[lts_pkg::TIME_MIN +: 6]  = s_reg.alarm.minute;
          s_next.rd_data[lts_pkg::TIME_HOUR +: 5] = s_reg.alarm.hour;
          s_next.rd_data[lts_pkg::TIME_PM]        = s_reg.alarm_pm;
          s_next.rd_data[lts_pkg::TIME_FMT12]     = s_reg.alarm_fmt12;
        end
        lts_pkg::REG_ALARM_DATE:
        begin
          s_next.rd_data[lts_pkg::DATE_DAY +: 5]   = s_reg.alarm.day;
          s_next.rd_data[lts_pkg::DATE_MONTH +: 4] = s_reg.alarm.month;
          s_next.rd_data[lts_pkg::DATE_YEAR +: 12] = s_reg.alarm.year;
        end
        lts_pkg::REG_STATUS:
        begin
          s_next.rd_data[lts_pkg::STAT_STATE +: 3] = s_reg.st;
          s_next.rd_data[lts_pkg::STAT_CLASH]      = clash;
          s_next.rd_data[lts_pkg::STAT_TMR_DONE]   = s_reg.tmr_done;
        end
        lts_pkg::REG_SCAN_PASS: s_next.rd_data[lts_pkg::CNT_W-1:0] = s_reg.scan_cnt;
        lts_pkg::REG_ARM_PASS:  s_next.rd_data[lts_pkg::CNT_W-1:0] = s_reg.arm_cnt;
        default:                s_next.rd_data = '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      s_reg               <= '0;
      s_reg.st            <= lts_pkg::LTS_IDLE;
      s_reg.arm_src       <= lts_pkg::SRC_IMM;
      s_reg.scan_src      <= lts_pkg::SRC_IMM;
      s_reg.tb_out_sel    <= lts_pkg::TB_SEL_W'(1);
      s_reg.scan_interval <= lts_pkg::MS_ONE;
      s_reg.arm_count     <= lts_pkg::CNT_ONE;
    end
    else
      s_reg <= s_next;
  end

endmodule // lts_sequencer

// File: sim/lts_checker.sv
// Port-level assertions for the trigger sequencer
`timescale 1ns/1ps
module lts_checker (
  input wire logic              sys_clk,
  input wire logic              rst,
  input wire logic [7:0]        reg_addr,
  input wire logic              reg_rd,
  input wire logic [31:0]       reg_rdata,
  input wire lts_pkg::lts_evt_t evt_in,
  input wire logic              act_start,
  input wire logic              done_out,
  input wire logic              ext_out,
  input wire logic [5:0]        tbus_out
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  act_pulse_a: assert property (act_start |=> !act_start)
    else $error("action start longer than one cycle");
  act_alone_a: assert property (act_start |-> !done_out && !ext_out)
    else $error("start overlaps completion");
  done_cause_a: assert property (done_out |-> $past(evt_in.act_done) && !$past(evt_in.act_done, 2))
    else $error("completion without action edge");
  ext_cause_a: assert property (ext_out |-> $past(evt_in.act_done) && !$past(evt_in.act_done, 2))
    else $error("return trigger without action edge");
  tbus_ret_a: assert property (|tbus_out |-> $onehot(tbus_out) && !ext_out && done_out)
    else $error("bad trigger bus return pulse");
  rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside read slot");
  unmapped_rd_a: assert property (reg_rd && reg_addr > 8'h24 |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  rst_quiet_a: assert property (disable iff (1'b0)
    rst |=> !act_start && !done_out && !ext_out && tbus_out == 6'h00)
    else $error("outputs active after reset");
  act_c: cover property (act_start);
  ext_c: cover property (ext_out);
  tbus_c: cover property (|tbus_out);
endmodule // lts_checker
bind lts_sequencer lts_checker chk_i (.sys_clk, .rst, .reg_addr, .reg_rd, .reg_rdata, .evt_in,
  .act_start, .done_out, .ext_out, .tbus_out);

// File: sim/lts_partner.sv
// Device action stand-in: answers each start with one completion pulse
`timescale 1ns/1ps
module lts_partner (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic act_start,
  input wire logic slow,
  output logic     act_done
);
  int left;
  always @(posedge sys_clk)
  begin
    if (rst || act_start)
      left <= rst ? 0 : (slow ? 6 : 1);
    else if (left > 0)
      left <= left - 1;
    act_done <= !rst && !act_start && left == 1;
  end
endmodule // lts_partner

// File: sim/lts_sequencer_bench.sv
// Directed bench for the trigger sequencer
`timescale 1ns/1ps
module lts_sequencer_bench;
  localparam int MSC = 4;
  localparam lts_pkg::lts_cal_t ALARM = '{12'h0, 4'h1, 5'h01, 5'h05, 6'h00, 6'h01};
  logic sys_clk, rst, reg_wr, reg_rd, slow, done_p, act_start, done_out, ext_out;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [10:0] ev;
  logic [5:0]  tbus_out;
  lts_pkg::lts_cal_t cal_now;
  int error_cnt, compares, cyc, acts, exts, tact, t0, l0, dones;
  logic [2:0]  srcs [6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h1, 3'h3};
  logic [11:0] evs [6] = '{12'h400, 12'h200, 12'h100, 12'h001, 12'h200, 12'h200};
  wire lts_pkg::lts_evt_t evt = {ev[10:7], done_p, ev[5:0]};
  lts_sequencer #(.MS_CYCLES(MSC)) uut (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .evt_in(evt), .cal_now, .act_start, .done_out, .ext_out, .tbus_out);
  lts_partner dev (.sys_clk, .rst, .act_start, .slow, .act_done(done_p));
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Counted mid-cycle so tasks never race the registered pulses
  always @(negedge sys_clk)
  begin
    cyc++;
    acts += act_start;
    dones += done_out;
    exts += ext_out + (|tbus_out);
    if (act_start)
      tact = cyc;
  end
  function automatic logic [31:0] cf(input logic [2:0] a, s, b);
    return {16'h0, 3'h1, 3'h0, b, s, a, 1'b1};
  endfunction
  task automatic give_verdict;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, e);
    compares++;
    if (g !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    chk(reg_rdata, e);
  endtask
  // Start or reconfigure, fire events e, expect n device actions
  task automatic run(input logic [31:0] c, input logic [11:0] e, input int n);
    int a0;
    int k;
    wr(8'h00, c);
    a0 = acts;
    t0 = cyc;
    if (e != 0)
    begin
      repeat (8) @(posedge sys_clk);
      chk(acts - a0, 0);
      @(posedge sys_clk);
      ev <= e[10:0];
      cal_now <= e[11] ? ALARM : '0;
      @(posedge sys_clk);
      ev <= '0;
      cal_now <= '0;
    end
    for (k = 0; k < (n > 0 ? 400 : 40) && acts - a0 < n; k++)
      @(posedge sys_clk);
    if (k == 400)
    begin
      error_cnt++;
      give_verdict;
    end
    repeat (20) @(posedge sys_clk);
    chk(acts - a0, n);
  endtask
  initial
  begin
    {reg_wr, reg_rd, slow, ev, reg_addr, reg_wdata} = '0;
    cal_now = '0;
    rst = 1'b1;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    rd(8'h08, 1);
    rd(8'h0C, 0);
    rd(8'h10, 1);
    rd(8'h1C, 0);
    rd(8'h40, 0);
    wr(8'h0C, 32'h000FFFFF);
    rd(8'h0C, 32'h0001869F);
    wr(8'h08, 0);
    rd(8'h08, 1);
    wr(8'h04, 32'hFFFFFFFF);
    rd(8'h04, 32'h3B9AC9FF);
    wr(8'h04, 0);
    wr(8'h0C, 1);
    for (int i = 0; i < 6; i++)
    begin
      slow <= i[0];
      run(cf(0, srcs[i], 4), evs[i], 1);
      run(cf(srcs[i], 0, 4), evs[i], 1);
    end
    run(cf(7, 0, 4), 12'hFBF, 0);
    run(cf(0, 0, 4), 0, 1);
    run(cf(0, 7, 4), 12'hFBF, 0);
    run(cf(0, 0, 4), 0, 1);
    wr(8'h14, 32'h5001);
    wr(8'h18, 32'h21);
    run(cf(6, 0, 4), 12'h200, 0);
    run(cf(6, 0, 4), 12'h800, 1);
    run(cf(0, 0, 0), 12'h080, 1);
    run(cf(0, 0, 4), 0, 1);
    l0 = tact - t0;
    wr(8'h04, 2);
    run(cf(0, 0, 4), 0, 1);
    chk(tact - t0 - l0, 2 * MSC);
    wr(8'h04, 0);
    wr(8'h0C, 3);
    wr(8'h10, 2);
    run(cf(0, 0, 4), 0, 6);
    rd(8'h20, 0);
    rd(8'h24, 0);
    wr(8'h10, 1);
    wr(8'h08, 3);
    wr(8'h0C, 2);
    run(cf(0, 5, 4), 0, 2);
    wr(8'h0C, 1);
    run(cf(0, 1, 6), 0, 1);
    chk(exts, 0);
    l0 = exts;
    run(cf(1, 0, 5), 0, 1);
    run(cf(4, 0, 5), 0, 1);
    chk(exts - l0, 2);
    chk(dones, acts);
    give_verdict;
  end
endmodule // lts_sequencer_bench
